// *** rtl/e1s_status_bank.sv ***
// E1 receive synchronization status word and page 3 status read bank
`timescale 1ns/1ps
`include "e1s_consts.svh"

module e1s_status_bank
	import e1s_pkg::*;
#(
	parameter logic [24:0] CRC4_TIMEOUT_CYC = 25'(`E1S_CRC4_TIMEOUT_CYC),
	parameter logic [24:0] RED_ALARM_CYC = 25'(`E1S_RED_ALARM_CYC),
	// Identification value is arbitrary
	parameter logic [7:0] IDENTITY_CODE = `E1S_IDENTITY_DEFAULT
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire e1s_host_req_type i_host_req,
	input wire e1s_line_state_type i_line,
	input wire e1s_page3_words_type i_words,
	input wire logic i_maintenance_mode,
	input wire logic i_auto_interwork_en,
	output logic [7:0] o_rdata,
	output logic o_rdata_valid,
	output logic [7:0] o_frame_align_status,
	output logic o_force_reframe
);

	// --------------------------------------------------------------------------
	// Declarations
	// --------------------------------------------------------------------------
	e1s_search_state_type search_state;
	e1s_search_state_type next_search_state;
	logic frame_align_loss;
	logic multiframe_align_loss;
	logic crc4_multiframe_loss;
	logic crc4_far_end_capable;
	logic rx_ebit_first;
	logic rx_ebit_second;
	logic crc4_search_timeout;
	logic sustained_frame_loss_alarm;
	logic crc4_timer_run;
	logic crc4_timer_expired;
	logic red_timer_expired;
	logic timeout_event;
	logic page_hit;
	logic [7:0] status_word;
	logic [7:0] next_rdata;

	// --------------------------------------------------------------------------
	// Basic frame alignment indication
	// --------------------------------------------------------------------------
	// Registered so every bit of the word is taken at one instant
	// Reset reads as lost in host reads, but o_frame_align_status resets to all zero, which shows the frame loss bit clear
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			frame_align_loss <= `E1S_LOSS_RESET;
		end else begin
			frame_align_loss <= i_line.frame_align_loss;
		end
	end

	// --------------------------------------------------------------------------
	// Multiframe alignment indication
	// --------------------------------------------------------------------------
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			multiframe_align_loss <= `E1S_LOSS_RESET;
		end else begin
			multiframe_align_loss <= i_line.multiframe_align_loss;
		end
	end

	// --------------------------------------------------------------------------
	// CRC-4 multiframe alignment indication
	// --------------------------------------------------------------------------
	// Also steers the search supervisor, so it shares the one-cycle delay
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			crc4_multiframe_loss <= `E1S_LOSS_RESET;
		end else begin
			crc4_multiframe_loss <= i_line.crc4_multiframe_loss;
		end
	end

	// --------------------------------------------------------------------------
	// Far end CRC-4 capability
	// --------------------------------------------------------------------------
	// Assumed not capable until the framer says otherwise
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			crc4_far_end_capable <= `E1S_CAPABLE_RESET;
		end else begin
			crc4_far_end_capable <= i_line.crc4_far_end_capable;
		end
	end

	// --------------------------------------------------------------------------
	// E-bit capture
	// --------------------------------------------------------------------------
	e1s_ebit_capture u_ebit (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_multiframe_done(i_line.multiframe_done),
		.i_rx_ebit_first(i_line.rx_ebit_first),
		.i_rx_ebit_second(i_line.rx_ebit_second),
		.o_rx_ebit_first(rx_ebit_first),
		.o_rx_ebit_second(rx_ebit_second)
	);

	// --------------------------------------------------------------------------
	// CRC-4 search supervision
	// --------------------------------------------------------------------------
	// Timer runs only while basic alignment holds and CRC-4 is still sought
	assign crc4_timer_run = (search_state == E1S_ST_CRC4_HUNT) && !frame_align_loss &&
		crc4_multiframe_loss;

	e1s_timer #(
		.LIMIT(CRC4_TIMEOUT_CYC)
	) u_crc4_timer (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_run(crc4_timer_run),
		.o_expired(crc4_timer_expired)
	);

	assign timeout_event = (search_state == E1S_ST_CRC4_HUNT) && crc4_timer_run &&
		crc4_timer_expired;

	always_comb begin
		next_search_state = search_state;
		unique case (search_state)
			E1S_ST_FRAME_LOST: begin
				// Basic alignment detected starts the 8 ms window
				if (!frame_align_loss) begin
					next_search_state = E1S_ST_CRC4_HUNT;
				end
			end
			E1S_ST_CRC4_HUNT: begin
				if (frame_align_loss) begin
					next_search_state = E1S_ST_FRAME_LOST;
				end else if (!crc4_multiframe_loss) begin
					next_search_state = E1S_ST_CRC4_LOCKED;
				end else if (timeout_event) begin
					next_search_state = E1S_ST_TIMED_OUT;
				end
			end
			E1S_ST_CRC4_LOCKED: begin
				if (frame_align_loss) begin
					next_search_state = E1S_ST_FRAME_LOST;
				end else if (crc4_multiframe_loss) begin
					next_search_state = E1S_ST_CRC4_HUNT;
				end
			end
			E1S_ST_TIMED_OUT: begin
				if (frame_align_loss) begin
					next_search_state = E1S_ST_FRAME_LOST;
				end else if (!crc4_multiframe_loss) begin
					next_search_state = E1S_ST_CRC4_LOCKED;
				end
			end
		endcase
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			search_state <= E1S_ST_FRAME_LOST;
		end else begin
			search_state <= next_search_state;
		end
	end

	// --------------------------------------------------------------------------
	// CRC-4 timeout flag
	// --------------------------------------------------------------------------
	// Set wins over clear; held until CRC-4 locks or basic frame alignment is lost
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			crc4_search_timeout <= 1'b0;
		end else if (timeout_event) begin
			crc4_search_timeout <= 1'b1;
		end else if (frame_align_loss || !crc4_multiframe_loss) begin
			crc4_search_timeout <= 1'b0;
		end
	end

	// --------------------------------------------------------------------------
	// Forced reframe
	// --------------------------------------------------------------------------
	// One pulse per timeout in maintenance mode; interworking mode keeps the alignment instead
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_force_reframe <= 1'b0;
		end else begin
			o_force_reframe <= timeout_event && i_maintenance_mode &&
				!i_auto_interwork_en;
		end
	end

	// --------------------------------------------------------------------------
	// Sustained frame loss alarm
	// --------------------------------------------------------------------------
	// Timer restarts on any moment of alignment, so the loss must be unbroken
	e1s_timer #(
		.LIMIT(RED_ALARM_CYC)
	) u_red_timer (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_run(frame_align_loss),
		.o_expired(red_timer_expired)
	);

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			sustained_frame_loss_alarm <= 1'b0;
		end else if (!frame_align_loss) begin
			sustained_frame_loss_alarm <= 1'b0;
		end else if (red_timer_expired) begin
			sustained_frame_loss_alarm <= 1'b1;
		end
	end

	// --------------------------------------------------------------------------
	// Synchronization status word
	// --------------------------------------------------------------------------
	always_comb begin
		status_word = `E1S_ZERO_BYTE;
		status_word[`E1S_BIT_FRAME_LOSS] = frame_align_loss;
		status_word[`E1S_BIT_MF_LOSS] = multiframe_align_loss;
		status_word[`E1S_BIT_CRC4_LOSS] = crc4_multiframe_loss;
		status_word[`E1S_BIT_EBIT_FIRST] = rx_ebit_first;
		status_word[`E1S_BIT_EBIT_SECOND] = rx_ebit_second;
		status_word[`E1S_BIT_CRC4_TIMEOUT] = crc4_search_timeout;
		status_word[`E1S_BIT_RED_ALARM] = sustained_frame_loss_alarm;
		status_word[`E1S_BIT_FAR_CAPABLE] = crc4_far_end_capable;
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_frame_align_status <= `E1S_ZERO_BYTE;
		end else begin
			o_frame_align_status <= status_word;
		end
	end

	// --------------------------------------------------------------------------
	// Host read decode
	// --------------------------------------------------------------------------
	// Pure multiplexer: nothing here feeds back into the status state
	assign page_hit = (i_host_req.page == `E1S_STATUS_PAGE);

	always_comb begin
		next_rdata = `E1S_ZERO_BYTE;
		if (page_hit) begin
			unique case (i_host_req.addr)
				`E1S_ADDR_SYNC_STATUS: next_rdata = status_word;
				`E1S_ADDR_TIMER: next_rdata = i_words.timer_status;
				`E1S_ADDR_PHASE_HI: next_rdata = i_words.phase_status_high;
				`E1S_ADDR_PHASE_LO: next_rdata = i_words.phase_status_low;
				`E1S_ADDR_RX_FAS: next_rdata = i_words.rx_frame_align_signal;
				`E1S_ADDR_RX_SIGNAL: next_rdata = i_words.rx_signal_status;
				`E1S_ADDR_JITTER: next_rdata = i_words.jitter_attenuator_status;
				`E1S_ADDR_RX_NFAS: next_rdata = i_words.rx_non_frame_align_signal;
				`E1S_ADDR_RX_MFAS: next_rdata = i_words.rx_multiframe_align_signal;
				`E1S_ADDR_SPARE_BITS: next_rdata = i_words.spare_bits_report;
				`E1S_ADDR_ALARM2: next_rdata = i_words.alarm_status_second;
				`E1S_ADDR_RESERVED: next_rdata = `E1S_ZERO_BYTE;
				`E1S_ADDR_LINE_PEAK: next_rdata = i_words.line_peak_level;
				`E1S_ADDR_EQ_PEAK: next_rdata = i_words.equalized_peak_level;
				`E1S_ADDR_IDENTITY: next_rdata = IDENTITY_CODE;
				default: next_rdata = `E1S_ZERO_BYTE;
			endcase
		end
	end

	// --------------------------------------------------------------------------
	// Read data register
	// --------------------------------------------------------------------------
	// Data holds between reads; no write port exists, so writes have no path
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= `E1S_ZERO_BYTE;
		end else if (i_host_req.rd) begin
			o_rdata <= next_rdata;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rdata_valid <= 1'b0;
		end else begin
			o_rdata_valid <= i_host_req.rd;
		end
	end

endmodule

// *** inc/e1s_consts.svh ***
// Constant macros for the E1 receive synchronization status bank
`ifndef E1S_CONSTS_SVH
`define E1S_CONSTS_SVH

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
`define E1S_CLK_MHZ 200
`define E1S_CRC4_TIMEOUT_MS 8
`define E1S_RED_ALARM_MS 100
`define E1S_CRC4_TIMEOUT_CYC (`E1S_CRC4_TIMEOUT_MS * `E1S_CLK_MHZ * 1000)
`define E1S_RED_ALARM_CYC (`E1S_RED_ALARM_MS * `E1S_CLK_MHZ * 1000)
`define E1S_TIMER_W 25

// ----------------------------------------------------------------------------
// Paging and addresses
// ----------------------------------------------------------------------------
`define E1S_PAGE_W 3
`define E1S_ADDR_W 5
`define E1S_DATA_W 8
`define E1S_STATUS_PAGE 3'h3
`define E1S_ADDR_SYNC_STATUS 5'h10
`define E1S_ADDR_TIMER 5'h12
`define E1S_ADDR_PHASE_HI 5'h13
`define E1S_ADDR_PHASE_LO 5'h14
`define E1S_ADDR_RX_FAS 5'h15
`define E1S_ADDR_RX_SIGNAL 5'h16
`define E1S_ADDR_JITTER 5'h17
`define E1S_ADDR_RX_NFAS 5'h18
`define E1S_ADDR_RX_MFAS 5'h19
`define E1S_ADDR_SPARE_BITS 5'h1a
`define E1S_ADDR_ALARM2 5'h1b
`define E1S_ADDR_RESERVED 5'h1c
`define E1S_ADDR_LINE_PEAK 5'h1d
`define E1S_ADDR_EQ_PEAK 5'h1e
`define E1S_ADDR_IDENTITY 5'h1f

// ----------------------------------------------------------------------------
// Synchronization status word fields
// ----------------------------------------------------------------------------
`define E1S_BIT_FRAME_LOSS 7
`define E1S_BIT_MF_LOSS 6
`define E1S_BIT_CRC4_LOSS 5
`define E1S_BIT_EBIT_FIRST 4
`define E1S_BIT_EBIT_SECOND 3
`define E1S_BIT_CRC4_TIMEOUT 2
`define E1S_BIT_RED_ALARM 1
`define E1S_BIT_FAR_CAPABLE 0

// ----------------------------------------------------------------------------
// Reset and read values
// ----------------------------------------------------------------------------
`define E1S_ZERO_BYTE 8'h00
`define E1S_IDENTITY_DEFAULT 8'h5a
`define E1S_TIMER_ZERO 25'h0000000
`define E1S_TIMER_ONE 25'h0000001
`define E1S_LOSS_RESET 1'b1
`define E1S_CAPABLE_RESET 1'b0

`endif

// *** inc/e1s_pkg.sv ***
// Types shared by the E1 receive synchronization status bank
package e1s_pkg;

	// --------------------------------------------------------------------------
	// CRC-4 search supervision states
	// --------------------------------------------------------------------------
	typedef enum logic [1:0] {
		E1S_ST_FRAME_LOST = 2'b00,
		E1S_ST_CRC4_HUNT = 2'b01,
		E1S_ST_CRC4_LOCKED = 2'b10,
		E1S_ST_TIMED_OUT = 2'b11
	} e1s_search_state_type;

	// --------------------------------------------------------------------------
	// Host read request
	// --------------------------------------------------------------------------
	typedef struct packed {
		logic rd;
		logic [2:0] page;
		logic [4:0] addr;
	} e1s_host_req_type;

	// --------------------------------------------------------------------------
	// Received line alignment indications from the framer
	// --------------------------------------------------------------------------
	typedef struct packed {
		logic frame_align_loss;
		logic multiframe_align_loss;
		logic crc4_multiframe_loss;
		logic crc4_far_end_capable;
		logic multiframe_done;
		logic rx_ebit_first;
		logic rx_ebit_second;
	} e1s_line_state_type;

	// --------------------------------------------------------------------------
	// Other page 3 status words, supplied by their own blocks
	// --------------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] timer_status;
		logic [7:0] phase_status_high;
		logic [7:0] phase_status_low;
		logic [7:0] rx_frame_align_signal;
		logic [7:0] rx_signal_status;
		logic [7:0] jitter_attenuator_status;
		logic [7:0] rx_non_frame_align_signal;
		logic [7:0] rx_multiframe_align_signal;
		logic [7:0] spare_bits_report;
		logic [7:0] alarm_status_second;
		logic [7:0] line_peak_level;
		logic [7:0] equalized_peak_level;
	} e1s_page3_words_type;

endpackage

// *** rtl/e1s_timer.sv ***
// Saturating run timer that flags a continuous run of LIMIT cycles
`timescale 1ns/1ps
`include "e1s_consts.svh"

module e1s_timer
	import e1s_pkg::*;
#(
	parameter logic [24:0] LIMIT = 25'h0000010
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_run,
	output logic o_expired
);

	logic [`E1S_TIMER_W-1:0] count;

	// --------------------------------------------------------------------------
	// Counter
	// --------------------------------------------------------------------------
	// Restarts from zero whenever the run condition drops
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			count <= `E1S_TIMER_ZERO;
		end else if (!i_run) begin
			count <= `E1S_TIMER_ZERO;
		end else if (count != LIMIT) begin
			count <= count + `E1S_TIMER_ONE;
		end
	end

	// --------------------------------------------------------------------------
	// Expiry flag
	// --------------------------------------------------------------------------
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_expired <= 1'b0;
		end else if (!i_run) begin
			o_expired <= 1'b0;
		end else if (count == LIMIT - `E1S_TIMER_ONE) begin
			o_expired <= 1'b1;
		end
	end

endmodule

// *** rtl/e1s_ebit_capture.sv ***
// Holds the two E-bits of the last completed multiframe
`timescale 1ns/1ps
`include "e1s_consts.svh"

module e1s_ebit_capture
	import e1s_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_multiframe_done,
	input wire logic i_rx_ebit_first,
	input wire logic i_rx_ebit_second,
	output logic o_rx_ebit_first,
	output logic o_rx_ebit_second
);

	// --------------------------------------------------------------------------
	// Capture
	// --------------------------------------------------------------------------
	// Both bits change together so a read never mixes two multiframes
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rx_ebit_first <= 1'b0;
			o_rx_ebit_second <= 1'b0;
		end else if (i_multiframe_done) begin
			o_rx_ebit_first <= i_rx_ebit_first;
			o_rx_ebit_second <= i_rx_ebit_second;
		end
	end

endmodule

// *** verif/e1s_status_bank_chk.sv ***
// Concurrent checks on the status bank ports
`timescale 1ns/1ps
module e1s_status_bank_chk
	import e1s_pkg::*;
#(
	parameter logic [24:0] CRC4_TIMEOUT_CYC = 25'h14,
	parameter logic [24:0] RED_ALARM_CYC = 25'h28
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire e1s_host_req_type i_host_req,
	input wire e1s_line_state_type i_line,
	input wire logic i_maintenance_mode,
	input wire logic i_auto_interwork_en,
	input wire logic [7:0] o_rdata,
	input wire logic o_rdata_valid,
	input wire logic [7:0] o_frame_align_status,
	input wire logic o_force_reframe
);
	// ------------------------------------------------------------------
	// Helper run counters
	// ------------------------------------------------------------------
	// Counted from the inputs; slack of 8 absorbs the internal pipeline
	logic [1:0] up_cnt;
	logic [24:0] red_run;
	logic [24:0] hunt_run;
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst)
			up_cnt <= 2'h0;
		else if (up_cnt != 2'h3)
			up_cnt <= up_cnt + 2'h1;
	end
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst)
			red_run <= 25'h0;
		else if (!i_line.frame_align_loss)
			red_run <= 25'h0;
		else if (red_run != '1)
			red_run <= red_run + 25'h1;
	end
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst)
			hunt_run <= 25'h0;
		else if (i_line.frame_align_loss || !i_line.crc4_multiframe_loss)
			hunt_run <= 25'h0;
		else if (hunt_run != '1)
			hunt_run <= hunt_run + 25'h1;
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_rst);

	property follow_p(logic b, logic s);
		(up_cnt == 2'h3) && (b == $past(b)) && ($past(b) == $past(b, 2)) |-> s == b;
	endproperty

	frame_loss_a: assert property (follow_p(i_line.frame_align_loss, o_frame_align_status[7]))
		else $error("frame loss bit wrong");
	mf_loss_a: assert property (follow_p(i_line.multiframe_align_loss, o_frame_align_status[6]))
		else $error("multiframe loss bit wrong");
	crc_loss_a: assert property (follow_p(i_line.crc4_multiframe_loss, o_frame_align_status[5]))
		else $error("crc4 loss bit wrong");
	far_capable_a: assert property (follow_p(i_line.crc4_far_end_capable, o_frame_align_status[0]))
		else $error("far end capable bit wrong");
	ebit_hold_a: assert property (i_line.multiframe_done ##1 !i_line.multiframe_done [*2]
		|=> o_frame_align_status[4] == $past(i_line.rx_ebit_first, 3)
		&& o_frame_align_status[3] == $past(i_line.rx_ebit_second, 3)) else $error("e-bit wrong");
	crc_timeout_a: assert property (hunt_run == CRC4_TIMEOUT_CYC + 25'h8 |-> o_frame_align_status[2])
		else $error("crc4 timeout bit not set");
	crc_early_a: assert property (hunt_run == CRC4_TIMEOUT_CYC - 25'h8 |-> !o_frame_align_status[2])
		else $error("crc4 timeout bit early");
	reframe_ok_a: assert property (o_force_reframe
		|-> $past(i_maintenance_mode) && !$past(i_auto_interwork_en)) else $error("reframe not allowed");
	reframe_due_a: assert property ($rose(o_frame_align_status[2]) && i_maintenance_mode
		&& !i_auto_interwork_en |-> o_force_reframe || $past(o_force_reframe)) else $error("no reframe");
	red_set_a: assert property (red_run == RED_ALARM_CYC + 25'h8 |-> o_frame_align_status[1])
		else $error("red alarm not set");
	red_clear_a: assert property ($fell(i_line.frame_align_loss) ##1 !i_line.frame_align_loss [*2]
		|=> !o_frame_align_status[1]) else $error("red alarm not cleared");
	read_ans_a: assert property (i_host_req.rd |=> o_rdata_valid)
		else $error("read not answered");
	reserved_zero_a: assert property (i_host_req.rd && (i_host_req.addr == 5'h1c
		|| i_host_req.page != 3'h3) |=> o_rdata == 8'h00) else $error("reserved read not zero");
	read_hold_a: assert property (!i_host_req.rd |=> $stable(o_rdata))
		else $error("read data changed");

	cover property (o_force_reframe);
	cover property ($rose(o_frame_align_status[1]));
	cover property (i_host_req.rd && i_host_req.addr == 5'h1c);
endmodule

bind e1s_status_bank e1s_status_bank_chk #(
	.CRC4_TIMEOUT_CYC(CRC4_TIMEOUT_CYC),
	.RED_ALARM_CYC(RED_ALARM_CYC)
) u_chk (
	.i_sys_clk(i_sys_clk),
	.i_rst(i_rst),
	.i_host_req(i_host_req),
	.i_line(i_line),
	.i_maintenance_mode(i_maintenance_mode),
	.i_auto_interwork_en(i_auto_interwork_en),
	.o_rdata(o_rdata),
	.o_rdata_valid(o_rdata_valid),
	.o_frame_align_status(o_frame_align_status),
	.o_force_reframe(o_force_reframe)
);

// *** verif/e1s_host_model.sv ***
// Host processor model issuing status page reads
`timescale 1ns/1ps
module e1s_host_model
	import e1s_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic [7:0] i_rdata,
	input wire logic i_rdata_valid,
	output e1s_host_req_type o_req
);
	initial o_req = '0;

	// ------------------------------------------------------------------
	// One read, request high for exactly one edge
	// ------------------------------------------------------------------
	task automatic rd(input logic [2:0] pg, input logic [4:0] ad, output logic [7:0] d,
		output bit ok);
		int n;
		ok = 1'b0;
		d = 8'h00;
		@(posedge i_sys_clk);
		o_req <= '{rd: 1'b1, page: pg, addr: ad};
		@(posedge i_sys_clk);
		o_req.rd <= 1'b0;
		// Bounded wait; answer is due at the edge that takes the request
		for (n = 0; n < 4 && !ok; n++) begin
			#1;
			if (i_rdata_valid === 1'b1) begin
				ok = 1'b1;
				d = i_rdata;
			end else
				@(posedge i_sys_clk);
		end
	endtask
endmodule

// *** verif/tb_top.sv ***
// Self-checking bench for the status bank
`timescale 1ns/1ps
module tb_top
	import e1s_pkg::*;
;
	localparam int CRC_N = 20;
	localparam int RED_N = 40;
	logic i_sys_clk = 1'b0;
	logic i_rst = 1'b1;
	e1s_host_req_type req;
	e1s_line_state_type ln = 7'h08;
	e1s_page3_words_type words = 96'h12131415161718191a1b1d1e;
	logic maint = 1'b0;
	logic auto_en = 1'b1;
	logic [7:0] rdata;
	logic rvalid;
	logic [7:0] stat;
	logic rf;
	int err_count = 0;
	int checks_done = 0;
	int rf_cnt = 0;
	// Page, address, expected read data
	logic [15:0] rows [18] = '{16'h7001, 16'h7100, 16'h7212, 16'h7313, 16'h7414, 16'h7515,
		16'h7616, 16'h7717, 16'h7818, 16'h7919, 16'h7a1a, 16'h7b1b, 16'h7c00, 16'h7d1d,
		16'h7e1e, 16'h7f3c, 16'h6000, 16'h5000};

	// Identification value is arbitrary
	e1s_status_bank #(
		.CRC4_TIMEOUT_CYC(25'h14),
		.RED_ALARM_CYC(25'h28),
		.IDENTITY_CODE(8'h3c)
	) dut (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_host_req(req),
		.i_line(ln),
		.i_words(words),
		.i_maintenance_mode(maint),
		.i_auto_interwork_en(auto_en),
		.o_rdata(rdata),
		.o_rdata_valid(rvalid),
		.o_frame_align_status(stat),
		.o_force_reframe(rf)
	);
	e1s_host_model host (
		.i_sys_clk(i_sys_clk),
		.i_rdata(rdata),
		.i_rdata_valid(rvalid),
		.o_req(req)
	);

	initial begin
		forever #2.5 i_sys_clk = ~i_sys_clk;
	end
	always @(posedge i_sys_clk) begin
		if (rf === 1'b1)
			rf_cnt++;
	end
	// Hang guard
	initial begin
		#300000;
		err_count++;
		wrap_up();
	end

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic wrap_up();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_sys_clk);
	endtask
	task automatic rd_chk(input logic [2:0] pg, input logic [4:0] ad, input logic [7:0] exp);
		logic [7:0] d;
		bit ok;
		host.rd(pg, ad, d, ok);
		if (!ok) begin
			err_count++;
			wrap_up();
		end else
			chk($sformatf("read %h %h", pg, ad), d, exp);
	endtask

	// ------------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------------
	initial begin
		int i;
		logic [15:0] r;
		tick(12);
		i_rst <= 1'b0;
		tick(4);
		for (i = 0; i < 18; i++) begin
			r = rows[i];
			rd_chk(r[15:13], r[12:8], r[7:0]);
		end
		// E-bits change after capture and must not leak in
		@(posedge i_sys_clk);
		ln.rx_ebit_first <= 1'b1;
		ln.multiframe_done <= 1'b1;
		@(posedge i_sys_clk);
		ln.multiframe_done <= 1'b0;
		ln.rx_ebit_first <= 1'b0;
		ln.rx_ebit_second <= 1'b1;
		tick(3);
		rd_chk(3'h3, 5'h10, 8'h11);
		@(posedge i_sys_clk);
		ln.multiframe_done <= 1'b1;
		@(posedge i_sys_clk);
		ln.multiframe_done <= 1'b0;
		ln.rx_ebit_second <= 1'b0;
		tick(3);
		rd_chk(3'h3, 5'h10, 8'h09);
		// Every mode pair; only maintenance without interworking reframes
		for (i = 0; i < 4; i++) begin
			@(posedge i_sys_clk);
			ln.crc4_multiframe_loss <= 1'b0;
			tick(3);
			rf_cnt = 0;
			maint <= i[1];
			auto_en <= i[0];
			ln.crc4_multiframe_loss <= 1'b1;
			tick(CRC_N + 20);
			chk("reframe count", 8'(rf_cnt), (i == 2) ? 8'h01 : 8'h00);
			rd_chk(3'h3, 5'h10, 8'h2d);
		end
		@(posedge i_sys_clk);
		ln.frame_align_loss <= 1'b1;
		ln.multiframe_align_loss <= 1'b1;
		tick(RED_N / 2);
		#1;
		chk("red early", 8'(stat[1]), 8'h00);
		tick(RED_N);
		#1;
		chk("status lost", stat, 8'heb);
		@(posedge i_sys_clk);
		ln.frame_align_loss <= 1'b0;
		ln.multiframe_align_loss <= 1'b0;
		tick(3);
		#1;
		chk("red cleared", stat, 8'h29);
		// Reset in mid-run drops the held e-bits
		@(posedge i_sys_clk);
		i_rst <= 1'b1;
		tick(2);
		i_rst <= 1'b0;
		tick(3);
		rd_chk(3'h3, 5'h10, 8'h21);
		@(posedge i_sys_clk);
		ln.crc4_far_end_capable <= 1'b0;
		tick(3);
		rd_chk(3'h3, 5'h10, 8'h20);
		rd_chk(3'h3, 5'h10, 8'h20);
		wrap_up();
	end
endmodule
